//--- hdl/srfp_top.v
// Functional notes
// - count out-of-band samples, interrupt at repeat count
// - in-band sample clears the persistence counter
// - repeat field decodes 0,1-3,5,10,5x(v-3)
// - compared channel chosen by threshold source select
// - buffer is 128 entries of two bytes
// - push into full buffer sets overflow, drops data
// - data at 0xfe/0xff, pointer wraps ff to fe
// - single byte and unlimited burst reads accepted
// - single reads pop only on upper byte
// - burst reads pop once per entry
// - empty buffer reads zero, pointer stays
// - data interrupt while unread data, level reported
// - source bits 1-6 push slots 0-5, two bytes
// - source bit 0 pushes status byte
// - fill level is 8-bit count 0 to 128
`timescale 1ns/1ps
`include "srfp_map.vh"
module srfp_top #(
    parameter [6:0] DEV_ADDR = 7'h2a // link address, arbitrary value
) (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // serial link pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    // measurement results
    input wire meas_done,
    input wire [7:0] measurement_status_byte,
    input wire [15:0] result_slot_0,
    input wire [15:0] result_slot_1,
    input wire [15:0] result_slot_2,
    input wire [15:0] result_slot_3,
    input wire [15:0] result_slot_4,
    input wire [15:0] result_slot_5,
    // threshold settings
    input wire [15:0] spectral_threshold_low,
    input wire [15:0] spectral_threshold_high,
    input wire [2:0] threshold_source_select,
    // flag clears
    input wire spectral_irq_clear,
    input wire overflow_clear,
    // status outputs
    output reg spectral_interrupt,
    output reg buffer_data_interrupt,
    output reg overflow_flag,
    output reg [7:0] buffer_fill_level
);
    // link states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_ACK_ADDR = 3'd2;
    localparam [2:0] ST_WDATA = 3'd3;
    localparam [2:0] ST_ACK_W = 3'd4;
    localparam [2:0] ST_RDATA = 3'd5;
    localparam [2:0] ST_ACK_R = 3'd6;

    reg [3:0] interrupt_repeat_count; // filter field
    reg [6:0] source_map; // push enables
    reg [6:0] wr_ptr; // next free entry
    reg [6:0] rd_ptr; // head entry
    reg [7:0] level; // unread entries
    reg [5:0] interrupt_filter_ctrl_cnt; // consecutive out-of-band samples
    reg [6:0] pending; // sources left to push this measurement
    reg [7:0] status_q; // latched status
    reg [95:0] slots_q; // latched slots
    reg scl_s1, scl_s2, scl_s3; // scl synchroniser and history
    reg sda_s1, sda_s2, sda_s3; // sda synchroniser and history
    reg [2:0] state; // link state
    reg [3:0] bit_cnt; // bits in current byte
    reg [7:0] shreg; // shift register
    reg rw_bit; // read direction
    reg ptr_set; // register pointer received
    reg [7:0] reg_ptr; // register address pointer
    reg master_ack; // master acked last read byte

    wire [15:0] head_data; // entry at the head
    wire [95:0] all_slots = {result_slot_5, result_slot_4, result_slot_3,
                             result_slot_2, result_slot_1, result_slot_0};
    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;
    wire start_cond = scl_s2 & sda_s3 & ~sda_s2;
    wire stop_cond = scl_s2 & ~sda_s3 & sda_s2;
    wire empty = (level == 8'h00);
    wire full = (level == `SRFP_DEPTH);

    // pointer advance with wrap over the data window
    function [7:0] next_reg_ptr;
        input [7:0] p;
        begin
            next_reg_ptr = (p == `SRFP_ADDR_DATA_HI) ? `SRFP_ADDR_DATA_LO : p + 8'h01;
        end
    endfunction

    // repeat field to sample count
    function [5:0] rep_target;
        input [3:0] v;
        begin
            if (v <= `SRFP_REP_DIRECT) begin
                rep_target = {2'b00, v};
            end else if (v == `SRFP_REP_FIVE_CODE) begin
                rep_target = `SRFP_REP_FIVE;
            end else if (v == `SRFP_REP_TEN_CODE) begin
                rep_target = `SRFP_REP_TEN;
            end else begin
                rep_target = `SRFP_REP_STEP * {2'b00, v - `SRFP_REP_DIRECT};
            end
        end
    endfunction

    // byte returned for a register read
    reg [7:0] rd_byte;
    always @* begin
        case (reg_ptr)
            `SRFP_ADDR_FILTER: rd_byte = {4'h0, interrupt_repeat_count};
            `SRFP_ADDR_SOURCE: rd_byte = {1'b0, source_map};
            `SRFP_ADDR_LEVEL: rd_byte = level;
            `SRFP_ADDR_DATA_LO: rd_byte = empty ? 8'h00 : head_data[7:0];
            `SRFP_ADDR_DATA_HI: rd_byte = empty ? 8'h00 : head_data[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    // pop when the upper data byte has gone out, in single and burst reads alike
    wire pop = (state == ST_RDATA) && scl_fall && (bit_cnt == 4'd7)
               && (reg_ptr == `SRFP_ADDR_DATA_HI) && !empty;

    // push engine: lowest pending source first
    reg [2:0] push_idx; // 0 status, 1..6 slots
    reg push_req;
    integer i;
    always @* begin
        push_idx = 3'd0;
        push_req = 1'b0;
        for (i = 6; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                push_idx = i[2:0];
                push_req = 1'b1;
            end
        end
    end
    wire [2:0] slot_idx = push_idx - 3'd1;
    wire [15:0] push_data = (push_idx == 3'd0) ? {8'h00, status_q}
                                               : slots_q[slot_idx * 16 +: 16];
    wire push_ok = push_req && !full;
    wire [7:0] next_level = level + {7'h00, push_ok} - {7'h00, pop};

    // channel under persistence watch
    wire [2:0] watch_sel = (threshold_source_select > 3'd5) ? 3'd0 : threshold_source_select;
    wire [15:0] watch_val = all_slots[watch_sel * 16 +: 16];
    wire outside = (watch_val < spectral_threshold_low) || (watch_val > spectral_threshold_high);
    wire [5:0] next_interrupt_filter_ctrl = (interrupt_filter_ctrl_cnt == `SRFP_REP_MAX) ? interrupt_filter_ctrl_cnt : interrupt_filter_ctrl_cnt + 6'h01;
    wire [5:0] target = rep_target(interrupt_repeat_count);
    wire interrupt_filter_ctrl_hit = meas_done && ((target == 6'h00) || (outside && next_interrupt_filter_ctrl >= target));

    // entry store
    srfp_ram u_ram (
        .core_clk(core_clk),
        .wr_en(push_ok),
        .wr_addr(wr_ptr),
        .wr_data(push_data),
        .rd_addr(rd_ptr),
        .rd_data(head_data)
    );

    // buffer pointers, level, capture and flags
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= 7'h00;
            rd_ptr <= 7'h00;
            level <= 8'h00;
            pending <= 7'h00;
            status_q <= 8'h00;
            slots_q <= 96'h0;
            overflow_flag <= 1'b0;
            buffer_fill_level <= 8'h00;
            buffer_data_interrupt <= 1'b0;
            interrupt_filter_ctrl_cnt <= 6'h00;
            spectral_interrupt <= 1'b0;
        end else begin
            // new measurement accepted only when the previous one is pushed
            if (meas_done && pending == 7'h00) begin
                pending <= source_map;
                status_q <= measurement_status_byte;
                slots_q <= all_slots;
            end else if (push_req) begin
                pending[push_idx] <= 1'b0;
            end
            if (push_ok) begin
                wr_ptr <= wr_ptr + 7'h01;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 7'h01;
            end
            level <= next_level;
            buffer_fill_level <= next_level;
            buffer_data_interrupt <= (next_level != 8'h00);
            // overflow: set wins over clear
            if (push_req && full) begin
                overflow_flag <= 1'b1;
            end else if (overflow_clear) begin
                overflow_flag <= 1'b0;
            end
            // persistence counter
            if (meas_done) begin
                interrupt_filter_ctrl_cnt <= outside ? next_interrupt_filter_ctrl : 6'h00;
            end
            if (interrupt_filter_ctrl_hit) begin
                spectral_interrupt <= 1'b1;
            end else if (spectral_irq_clear) begin
                spectral_interrupt <= 1'b0;
            end
        end
    end

    // link pin synchronisers
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    // link target state machine and register writes
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw_bit <= 1'b0;
            ptr_set <= 1'b0;
            reg_ptr <= 8'h00;
            master_ack <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            interrupt_repeat_count <= `SRFP_FILTER_RESET;
            source_map <= `SRFP_SOURCE_RESET;
        end else if (start_cond) begin
            // start or repeated start
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'd8) begin
                        // address byte complete
                        if (shreg[7:1] == DEV_ADDR) begin
                            rw_bit <= shreg[0];
                            sda_oe_n <= 1'b0;
                            state <= ST_ACK_ADDR;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        ptr_set <= 1'b0;
                        if (rw_bit) begin
                            shreg <= rd_byte;
                            sda_oe_n <= rd_byte[7];
                            state <= ST_RDATA;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state <= ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'd8) begin
                        // first byte sets the pointer, later bytes write registers
                        sda_oe_n <= 1'b0;
                        state <= ST_ACK_W;
                        if (!ptr_set) begin
                            reg_ptr <= shreg;
                            ptr_set <= 1'b1;
                        end else begin
                            if (reg_ptr == `SRFP_ADDR_FILTER) begin
                                interrupt_repeat_count <= shreg[3:0];
                            end
                            if (reg_ptr == `SRFP_ADDR_SOURCE) begin
                                source_map <= shreg[6:0];
                            end
                            reg_ptr <= next_reg_ptr(reg_ptr);
                        end
                    end
                end
                ST_ACK_W: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b1;
                        bit_cnt <= 4'h0;
                        state <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'd7) begin
                            // byte sent, release for the master's ack
                            sda_oe_n <= 1'b1;
                            reg_ptr <= next_reg_ptr(reg_ptr);
                            state <= ST_ACK_R;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe_n <= shreg[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise) begin
                        master_ack <= ~sda_s2;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            // burst continues with no length limit
                            bit_cnt <= 4'h0;
                            shreg <= rd_byte;
                            sda_oe_n <= rd_byte[7];
                            state <= ST_RDATA;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe_n <= 1'b1;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // srfp_top

//--- hdl/srfp_map.vh
`ifndef SRFP_MAP_VH
`define SRFP_MAP_VH

// register addresses on the serial link
`define SRFP_ADDR_FILTER 8'hcf
`define SRFP_ADDR_SOURCE 8'hfc
`define SRFP_ADDR_LEVEL 8'hfd
`define SRFP_ADDR_DATA_LO 8'hfe
`define SRFP_ADDR_DATA_HI 8'hff

// reset values
`define SRFP_FILTER_RESET 4'h0
`define SRFP_SOURCE_RESET 7'h00

// source map field positions
`define SRFP_SRC_STATUS 0
`define SRFP_SRC_SLOT0 1

// buffer geometry: 256 bytes as 128 two-byte entries
`define SRFP_DEPTH 8'h80
`define SRFP_PTR_W 7
`define SRFP_SLOTS 6

// repeat count decode
`define SRFP_REP_DIRECT 4'h3
`define SRFP_REP_FIVE_CODE 4'h4
`define SRFP_REP_TEN_CODE 4'h5
`define SRFP_REP_FIVE 6'h05
`define SRFP_REP_TEN 6'h0a
`define SRFP_REP_STEP 6'h05
`define SRFP_REP_MAX 6'h3f

`endif

//--- hdl/srfp_ram.v
`timescale 1ns/1ps
// entry store, written by the push engine, read combinationally at the head
module srfp_ram (
    // clock
    input wire core_clk,
    // write side
    input wire wr_en,
    input wire [6:0] wr_addr,
    input wire [15:0] wr_data,
    // read side
    input wire [6:0] rd_addr,
    output wire [15:0] rd_data
);
    reg [15:0] mem [0:127]; // 128 entries of two bytes

    // synchronous write
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule // srfp_ram

//--- testbench/srfp_checker.sv
`timescale 1ns/1ps
// watches the flags and the fill level of the result queue
module srfp_checker (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // strobes
    input wire meas_done,
    input wire spectral_irq_clear,
    input wire overflow_clear,
    // outputs
    input wire sda_out,
    input wire spectral_interrupt,
    input wire buffer_data_interrupt,
    input wire overflow_flag,
    input wire [7:0] buffer_fill_level
);
    reg [3:0] since_meas; // cycles since the last strobe, saturating
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // age of the last measurement strobe
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            since_meas <= 4'hf;
        else if (meas_done)
            since_meas <= 4'h0;
        else if (since_meas != 4'hf)
            since_meas <= since_meas + 4'h1;
    end
    level_bound_a: assert property (buffer_fill_level <= 8'h80)
        else $error("fill level above depth");
    data_irq_a: assert property (buffer_data_interrupt == (buffer_fill_level != 8'h00))
        else $error("data interrupt disagrees with level");
    level_step_a: assert property (buffer_fill_level <= $past(buffer_fill_level) + 8'h01)
        else $error("level rose by more than one");
    push_cause_a: assert property (buffer_fill_level > $past(buffer_fill_level) |-> since_meas <= 4'h9)
        else $error("entry pushed without a measurement");
    ovf_hold_a: assert property (overflow_flag && !overflow_clear |=> overflow_flag)
        else $error("overflow flag dropped");
    ovf_full_a: assert property ($rose(overflow_flag) |-> $past(buffer_fill_level) == 8'h80)
        else $error("overflow while not full");
    irq_hold_a: assert property (spectral_interrupt && !spectral_irq_clear |=> spectral_interrupt)
        else $error("spectral interrupt dropped");
    irq_cause_a: assert property ($rose(spectral_interrupt) |-> $past(meas_done))
        else $error("spectral interrupt without a sample");
    drive_low_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    cover property ($rose(overflow_flag));
    cover property ($rose(spectral_interrupt));
    cover property ($fell(buffer_data_interrupt));
endmodule // srfp_checker
bind srfp_top srfp_checker u_chk (.core_clk(core_clk), .reset_n(reset_n), .meas_done(meas_done),
    .spectral_irq_clear(spectral_irq_clear), .overflow_clear(overflow_clear), .sda_out(sda_out),
    .spectral_interrupt(spectral_interrupt), .buffer_data_interrupt(buffer_data_interrupt),
    .overflow_flag(overflow_flag), .buffer_fill_level(buffer_fill_level));

//--- testbench/srfp_host.sv
`timescale 1ns/1ps
// behavioural link master, open drain on the data wire, 48 ns bits
module srfp_host (
    // link pins
    output reg scl_in,
    output reg sda_pull,
    input wire sda_wire
);
    // idle: clock high, data released
    initial begin
        scl_in = 1'b1;
        sda_pull = 1'b0;
    end
    // one bit: data set while clock low, sampled late in the high phase
    task bit_io(input b, output r);
        begin
            #6 sda_pull = ~b;
            #18 scl_in = 1'b1;
            #23 r = sda_wire;
            #1 scl_in = 1'b0;
        end
    endtask
    // start or repeated start
    task start;
        begin
            #6 sda_pull = 1'b0;
            #18 scl_in = 1'b1;
            #12 sda_pull = 1'b1;
            #12 scl_in = 1'b0;
        end
    endtask
    // stop, leaves the bus idle
    task stop;
        begin
            #6 sda_pull = 1'b1;
            #18 scl_in = 1'b1;
            #12 sda_pull = 1'b0;
            #12;
        end
    endtask
    // byte out, ack from the device
    task wbyte(input [7:0] d, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
            bit_io(1'b1, r);
            ack = ~r;
        end
    endtask
    // byte in, master nacks the last one of the window reads
    task rbyte(input last, output [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                bit_io(1'b1, r);
                d = {d[6:0], r};
            end
            bit_io(last, r);
        end
    endtask
endmodule // srfp_host

//--- testbench/srfp_top_tb.sv
`timescale 1ns/1ps
// self-checking bench for the result queue and persistence filter
module srfp_top_tb;
    localparam [6:0] DEV = 7'h2a; // link address, arbitrary value
    localparam [15:0] IN_V = 16'h0150; // inside the band
    localparam [15:0] OUT_V = 16'h0300; // above the band
    reg core_clk, reset_n, meas_done, spectral_irq_clear, overflow_clear;
    reg [7:0] status;
    reg [15:0] slot [0:5];
    reg [2:0] sel;
    wire scl_in, sda_pull, sda_out, sda_oe_n, spectral_interrupt, buffer_data_interrupt, overflow_flag;
    wire [7:0] buffer_fill_level;
    wire sda_in = !(sda_pull || !sda_oe_n); // pulled up, low when either side pulls
    integer n_errors, num_checks, i, k;
    reg ack;
    reg [7:0] rd [0:15]; // bytes of the last read
    reg [9:0] rows [0:5]; // repeat code beside expected sample count
    srfp_top #(.DEV_ADDR(DEV)) DUT (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .meas_done(meas_done), .measurement_status_byte(status),
        .result_slot_0(slot[0]), .result_slot_1(slot[1]), .result_slot_2(slot[2]), .result_slot_3(slot[3]),
        .result_slot_4(slot[4]), .result_slot_5(slot[5]), .spectral_threshold_low(16'h0100),
        .spectral_threshold_high(16'h0200), .threshold_source_select(sel), .spectral_irq_clear(spectral_irq_clear),
        .overflow_clear(overflow_clear), .spectral_interrupt(spectral_interrupt),
        .buffer_data_interrupt(buffer_data_interrupt), .overflow_flag(overflow_flag),
        .buffer_fill_level(buffer_fill_level));
    srfp_host u_host (.scl_in(scl_in), .sda_pull(sda_pull), .sda_wire(sda_in));
    // verdict and end of run
    task test_done;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // flag compare
    task chk1(input got, input exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    // byte compare
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
            end
        end
    endtask
    // link transfer: n==0 writes wd at a, else reads n bytes from a
    task xfer(input [7:0] a, input integer n, input [7:0] wd);
        integer j;
        begin
            u_host.start;
            u_host.wbyte({DEV, 1'b0}, ack);
            chk1(ack, 1'b1);
            u_host.wbyte(a, ack);
            if (n == 0)
                u_host.wbyte(wd, ack);
            else begin
                u_host.start;
                u_host.wbyte({DEV, 1'b1}, ack);
                for (j = 0; j < n; j = j + 1) u_host.rbyte(j == n - 1, rd[j]);
            end
            u_host.stop;
        end
    endtask
    // n measurement strobes, spaced for a full push
    task pulse(input integer n);
        integer m;
        begin
            for (m = 0; m < n; m = m + 1) begin
                @(posedge core_clk) meas_done <= 1'b1;
                @(posedge core_clk) meas_done <= 1'b0;
                repeat (9) @(posedge core_clk);
                #1;
            end
        end
    endtask
    // one-cycle strobe on a clear input
    task clr(input which);
        begin
            @(posedge core_clk);
            if (which) overflow_clear <= 1'b1;
            else spectral_irq_clear <= 1'b1;
            @(posedge core_clk);
            overflow_clear <= 1'b0;
            spectral_irq_clear <= 1'b0;
            @(posedge core_clk);
            #1;
        end
    endtask
    // all slots to one value
    task set_slots(input [15:0] v);
        integer m;
        begin
            @(posedge core_clk);
            for (m = 0; m < 6; m = m + 1) slot[m] <= v;
        end
    endtask
    // clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // watchdog
    initial begin
        #200000;
        n_errors = n_errors + 1;
        test_done;
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        meas_done = 1'b0;
        spectral_irq_clear = 1'b0;
        overflow_clear = 1'b0;
        status = 8'h00;
        sel = 3'h0;
        for (k = 0; k < 6; k = k + 1) slot[k] = 16'h0000;
        n_errors = 0;
        num_checks = 0;
        rows[0] = {4'h1, 6'h01};
        rows[1] = {4'h3, 6'h03};
        rows[2] = {4'h4, 6'h05};
        rows[3] = {4'h5, 6'h0a};
        rows[4] = {4'h6, 6'h0f};
        rows[5] = {4'hf, 6'h3c};
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        // reset values, unmapped address
        chk8(buffer_fill_level, 8'h00);
        chk1(overflow_flag | spectral_interrupt | buffer_data_interrupt, 1'b0);
        xfer(8'hcf, 1, 8'h00);
        chk8(rd[0], 8'h00);
        xfer(8'hfc, 1, 8'h00);
        chk8(rd[0], 8'h00);
        xfer(8'h10, 1, 8'h00);
        chk8(rd[0], 8'h00);
        xfer(8'hcf, 0, 8'hff);
        xfer(8'hcf, 1, 8'h00);
        chk8(rd[0], 8'h0f);
        // repeat-count table, each row watching a different slot
        for (i = 0; i < 6; i = i + 1) begin
            xfer(8'hcf, 0, {4'h0, rows[i][9:6]});
            @(posedge core_clk);
            sel <= i[2:0];
            for (k = 0; k < 6; k = k + 1) slot[k] <= (k == i) ? IN_V : OUT_V;
            pulse(1); // in-band watched slot clears the count
            clr(1'b0);
            @(posedge core_clk) slot[i] <= OUT_V;
            pulse(rows[i][5:0] - 1);
            chk1(spectral_interrupt, 1'b0);
            pulse(1);
            chk1(spectral_interrupt, 1'b1);
        end
        // in-band sample in mid-run restarts the count
        xfer(8'hcf, 0, 8'h03);
        // count left over from the table starts from zero again
        set_slots(IN_V);
        pulse(1);
        set_slots(OUT_V);
        clr(1'b0);
        pulse(2);
        set_slots(IN_V);
        pulse(1);
        set_slots(OUT_V);
        pulse(2);
        chk1(spectral_interrupt, 1'b0);
        pulse(1);
        chk1(spectral_interrupt, 1'b1);
        // code zero interrupts on any sample
        xfer(8'hcf, 0, 8'h00);
        set_slots(IN_V);
        clr(1'b0);
        pulse(1);
        chk1(spectral_interrupt, 1'b1);
        // every source, fixed order, one burst across the wrap
        xfer(8'hfc, 0, 8'h7f);
        xfer(8'hfc, 1, 8'h00);
        chk8(rd[0], 8'h7f);
        @(posedge core_clk) status <= 8'ha5;
        for (k = 0; k < 6; k = k + 1) slot[k] <= 16'h1100 + k[15:0];
        pulse(1);
        chk8(buffer_fill_level, 8'h07);
        chk1(buffer_data_interrupt, 1'b1);
        xfer(8'hfe, 14, 8'h00);
        for (k = 0; k < 7; k = k + 1) begin
            chk8(rd[2 * k], k == 0 ? 8'ha5 : 8'(k - 1));
            chk8(rd[2 * k + 1], k == 0 ? 8'h00 : 8'h11);
        end
        chk8(buffer_fill_level, 8'h00);
        chk1(buffer_data_interrupt, 1'b0);
        // single reads pop on the upper byte only, empty reads zero
        xfer(8'hfc, 0, 8'h02);
        @(posedge core_clk) slot[0] <= 16'hbeef;
        pulse(1);
        xfer(8'hfe, 1, 8'h00);
        chk8(rd[0], 8'hef);
        chk8(buffer_fill_level, 8'h01);
        xfer(8'hff, 1, 8'h00);
        chk8(rd[0], 8'hbe);
        chk8(buffer_fill_level, 8'h00);
        xfer(8'hfe, 2, 8'h00);
        chk8(rd[0] | rd[1], 8'h00);
        chk8(buffer_fill_level, 8'h00);
        // fill to 128, one more overflows and is dropped
        for (k = 0; k < 129; k = k + 1) begin
            @(posedge core_clk) slot[0] <= 16'h5a00 + k[15:0];
            pulse(1);
            if (k == 127) begin
                chk8(buffer_fill_level, 8'h80);
                chk1(overflow_flag, 1'b0);
            end
        end
        chk1(overflow_flag, 1'b1);
        chk8(buffer_fill_level, 8'h80);
        xfer(8'hfe, 2, 8'h00);
        chk8(rd[0], 8'h00);
        chk8(rd[1], 8'h5a);
        clr(1'b1);
        chk1(overflow_flag, 1'b0);
        test_done;
    end
endmodule // srfp_top_tb
